/* File: sarsc_ana_model.sv */
// Behavioural model of the analog converter core and input selector
`timescale 1ns/10ps
module sarsc_ana_model
	import sarsc_pkg::*;
(
	// Clock
	input wire logic sys_clk,
	// Control from the sequencer
	input wire sarsc_ana_s ana,
	// Result back to the sequencer
	output logic [11:0] sar_result
);
	// ****************************************
	// Result generation
	// ****************************************
	logic [11:0] res_q = 12'h5a5;
	int n_clk = 0;
	// Junk until the last convert cycle, so a result taken early cannot pass by luck
	always @(posedge sys_clk) begin
		if (ana.en && ana.convert) begin
			if (n_clk < CONV_CYC - 2) begin
				res_q <= ~res_q;
			end else if (n_clk == CONV_CYC - 2) begin
				res_q <= ana.sel * 12'h1f0 + 12'h010; // Code 8 is the temperature sensor
			end
			n_clk <= n_clk + 1;
		end else begin
			res_q <= ~res_q;
			n_clk <= 0;
		end
	end
	assign sar_result = res_q;
endmodule

/* File: sarsc_pkg.sv */
// Package: constants and types for the SAR sequencer control block
package sarsc_pkg;
	// ****************************************
	// Timing
	// ****************************************
	localparam int SYS_HZ = 10_000_000;
	localparam int SAR_MAX_HZ = 18_000_000;
	localparam int CONV_CLKS = 18;
	// Converter clock divider from sys_clk, rounded up to stay under max
	localparam int CLK_DIV = (SYS_HZ + SAR_MAX_HZ - 1) / SAR_MAX_HZ;
	localparam int CONV_CYC = CONV_CLKS * CLK_DIV;
	localparam int NCH = 8;
	localparam int RES_W = 12;
	localparam int NEV = 3;

	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_CMD = 8'h04;
	localparam logic [7:0] OFF_CHEN = 8'h08;
	localparam logic [7:0] OFF_LIMIT = 8'h0c;
	localparam logic [7:0] OFF_STAT = 8'h10;
	localparam logic [7:0] OFF_MASK = 8'h14;
	localparam logic [7:0] OFF_STATE = 8'h18;
	localparam logic [2:0] BLK_CFG = 3'h1;
	localparam logic [2:0] BLK_RES = 3'h2;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CTRL_EN = 0;
	localparam int CTRL_SW = 1;
	localparam int CTRL_REF = 2;
	localparam int CTRL_CONT = 4;
	localparam int CMD_GO = 0;
	localparam int CMD_CH = 4;
	localparam int LIM_HI = 16;
	localparam int CFG_SAMP = 8;
	localparam int RES_OOR = 16;
	localparam int ST_RANGE = 0;
	localparam int ST_EOC = 1;
	localparam int ST_SCAN = 2;
	localparam int STA_CH = 4;
	localparam int STA_LP = 8;
	localparam logic [3:0] SEL_TEMP = 4'h8;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] CHEN_RST = 8'h01;
	localparam logic [11:0] LIM_LO_RST = 12'h000;
	localparam logic [11:0] LIM_HI_RST = 12'hfff;
	localparam logic [7:0] SAMP_RST = 8'h04;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_SAMP = 2'b01,
		S_CONV = 2'b11
	} sarsc_state_e;
	typedef struct packed {
		logic [3:0] sel;
		logic [7:0] samp;
	} sarsc_cfg_s;
	typedef struct packed {
		logic en;
		logic sample;
		logic convert;
		logic [3:0] sel;
		logic [1:0] refsel;
	} sarsc_ana_s;
	typedef struct packed {
		logic oor;
		logic [11:0] val;
	} sarsc_res_s;
endpackage

/* File: sarsc_top.sv */
// SAR converter sequencer control with Avalon-MM register slave
// Functional notes
// R1: Converter clock at most 18 MHz; result taken after 18 converter clocks.
// R2: Every completed conversion yields a 12-bit result word.
// R3: Eight channel slots, each picks one input and is enabled separately.
// R4: Scan steps through enabled channels itself with no idle cycles between.
// R5: Config bit selects automatic advance or software-driven channel switching.
// R6: Each channel keeps its own result buffer.
// R7: Per-channel sample window length held before each conversion starts.
// R8: Programmable low and high limits compared with every result.
// R9: Out-of-range interrupt raised on a single bad result, mid-scan.
// R10: Reference select picks supply, half supply, bandgap or external pin.
// R11: Temperature sensor selectable as a conversion input.
// R12: Converter and sequencer kept idle in deep low-power modes.
// R13: Below low or above high is out of range; flag latched until cleared.
`timescale 1ns/10ps
module sarsc_top
	import sarsc_pkg::*;
(
	// Clock, reset, enable
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic clk_en,
	// Avalon-MM slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Analog converter side
	input wire logic [11:0] sar_result,
	input wire logic lp_mode,
	output sarsc_ana_s ana,
	// Interrupt
	output logic irq
);
	// ****************************************
	// State
	// ****************************************
	logic wait_r;
	logic [31:0] rdata_r;
	logic en_r, sw_r, cont_r;
	logic [1:0] ref_r;
	logic [7:0] chen_r;
	logic [11:0] lo_r, hi_r;
	logic [NEV-1:0] stat_r, mask_r, stat_nxt;
	sarsc_cfg_s cfg_r [NCH];
	sarsc_res_s res_r [NCH];
	sarsc_state_e st_r, st_nxt;
	logic [2:0] cur_r, cur_nxt;
	logic [7:0] cnt_r, cnt_nxt;
	sarsc_ana_s ana_r, ana_nxt;
	logic irq_r;

	// ****************************************
	// Bus decode
	// ****************************************
	// Byte-lane mask; lanes not enabled keep their old bits
	wire [31:0] bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	wire [31:0] wd = avs_writedata & bmask;
	wire req = avs_read | avs_write;
	wire wr_go = clk_en & avs_write & ~wait_r;
	wire hit_ctrl = avs_address == OFF_CTRL;
	wire hit_cmd = avs_address == OFF_CMD;
	wire hit_chen = avs_address == OFF_CHEN;
	wire hit_lim = avs_address == OFF_LIMIT;
	wire hit_stat = avs_address == OFF_STAT;
	wire hit_mask = avs_address == OFF_MASK;
	wire hit_state = avs_address == OFF_STATE;
	wire hit_cfg = avs_address[7:5] == BLK_CFG;
	wire hit_res = avs_address[7:5] == BLK_RES;
	wire [2:0] widx = avs_address[4:2];
	wire [NEV-1:0] w1c = (wr_go & hit_stat) ? wd[NEV-1:0] : '0;

	// Write images: old value with the enabled byte lanes replaced, as plain wires so they follow the bus
	wire [31:0] ctrl_m = ({27'h0, cont_r, ref_r, sw_r, en_r} & ~bmask) | wd;
	wire [31:0] chen_m = ({24'h0, chen_r} & ~bmask) | wd;
	wire [31:0] lim_m = ({4'h0, hi_r, 4'h0, lo_r} & ~bmask) | wd;
	wire [31:0] mask_m = ({29'h0, mask_r} & ~bmask) | wd;

	// Lowest enabled channel at or above a start index; bit 3 set if none
	function automatic logic [3:0] next_from(input logic [7:0] en,
		input logic [3:0] from);
		logic [3:0] r;
		r = 4'h8;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (en[i] && 4'(i) >= from) begin
				r = {1'b0, 3'(i)};
			end
		end
		return r;
	endfunction

	// ****************************************
	// Read mux
	// ****************************************
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_ctrl) begin
			rd_mux[CTRL_EN] = en_r;
			rd_mux[CTRL_SW] = sw_r;
			rd_mux[CTRL_REF+:2] = ref_r;
			rd_mux[CTRL_CONT] = cont_r;
		end else if (hit_chen) begin
			rd_mux[7:0] = chen_r;
		end else if (hit_lim) begin
			rd_mux[11:0] = lo_r;
			rd_mux[LIM_HI+:12] = hi_r;
		end else if (hit_stat) begin
			rd_mux[NEV-1:0] = stat_r;
		end else if (hit_mask) begin
			rd_mux[NEV-1:0] = mask_r;
		end else if (hit_state) begin
			rd_mux[1:0] = st_r;
			rd_mux[STA_CH+:3] = cur_r;
			rd_mux[STA_LP] = lp_mode;
		end else if (hit_cfg) begin
			rd_mux[3:0] = cfg_r[widx].sel;
			rd_mux[CFG_SAMP+:8] = cfg_r[widx].samp;
		end else if (hit_res) begin
			rd_mux[11:0] = res_r[widx].val;
			rd_mux[RES_OOR] = res_r[widx].oor;
		end
	end

	// Wait state: low for one cycle after a request is seen, data set up
	// beforehand so it is stable at the completing edge
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wait_r <= 1'b1;
			rdata_r <= 32'h0000_0000;
		end else if (clk_en) begin
			wait_r <= ~(req & wait_r);
			if (avs_read & wait_r) begin
				rdata_r <= rd_mux;
			end
		end
	end

	// ****************************************
	// Control registers
	// ****************************************
	// One write path per register; unmapped writes are dropped
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			en_r <= 1'b0;
			sw_r <= 1'b0;
			cont_r <= 1'b0;
			ref_r <= 2'h0;
			chen_r <= CHEN_RST;
			lo_r <= LIM_LO_RST;
			hi_r <= LIM_HI_RST;
			mask_r <= '0;
		end else if (wr_go) begin
			if (hit_ctrl) begin
				en_r <= ctrl_m[CTRL_EN];
				sw_r <= ctrl_m[CTRL_SW]; // [R5]
				ref_r <= ctrl_m[CTRL_REF+:2]; // [R10]
				cont_r <= ctrl_m[CTRL_CONT];
			end else if (hit_chen) begin
				chen_r <= chen_m[7:0]; // [R3]
			end else if (hit_lim) begin
				lo_r <= lim_m[11:0]; // [R8]
				hi_r <= lim_m[LIM_HI+:12]; // [R8]
			end else if (hit_mask) begin
				mask_r <= mask_m[NEV-1:0];
			end
		end
	end

	// ****************************************
	// Per-channel config and result buffers
	// ****************************************
	wire conv_done = st_r == S_CONV && cnt_r == 8'h00;
	// Out of range is strictly below low or strictly above high
	wire oor = sar_result < lo_r || sar_result > hi_r; // [R8] [R13]
	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_ch
			wire [31:0] cfg_m = ({16'h0, cfg_r[gi].samp, 4'h0, cfg_r[gi].sel} & ~bmask) | wd;
			always_ff @(posedge sys_clk) begin
				if (reset) begin
					cfg_r[gi] <= '{sel: 4'(gi), samp: SAMP_RST};
					res_r[gi] <= '0;
				end else if (clk_en) begin
					if (wr_go && hit_cfg && widx == 3'(gi)) begin
						// Selector 8 routes the temperature sensor [R11]
						cfg_r[gi].sel <= cfg_m[3:0]; // [R3]
						cfg_r[gi].samp <= cfg_m[CFG_SAMP+:8]; // [R7]
					end
					if (conv_done && cur_r == 3'(gi)) begin
						res_r[gi] <= '{oor: oor, val: sar_result}; // [R2] [R6]
					end
				end
			end
		end
	endgenerate

	// ****************************************
	// Sequencer
	// ****************************************
	// Deep low-power modes remove the fast clock, so hold everything idle
	wire running = en_r & ~lp_mode; // [R12]
	wire go = wr_go & hit_cmd & wd[CMD_GO] & running;
	wire [3:0] first = next_from(chen_r, 4'h0);
	wire [3:0] later = next_from(chen_r, {1'b0, cur_r} + 4'h1);
	wire [2:0] sw_ch = wd[CMD_CH+:3];

	// Sample count for a channel; zero still gives one cycle
	function automatic logic [7:0] samp_of(input logic [2:0] ch);
		logic [7:0] s;
		s = cfg_r[ch].samp;
		return (s == 8'h00) ? 8'h00 : s - 8'h01;
	endfunction

	// Next channel loads in the last conversion cycle: no gap between slots
	always_comb begin
		st_nxt = st_r;
		cur_nxt = cur_r;
		cnt_nxt = cnt_r;
		case (st_r)
			S_IDLE: begin
				if (go && sw_r) begin
					st_nxt = S_SAMP; // [R5]
					cur_nxt = sw_ch;
					cnt_nxt = samp_of(sw_ch);
				end else if ((go || cont_r) && !sw_r && !first[3]) begin
					st_nxt = S_SAMP;
					cur_nxt = first[2:0];
					cnt_nxt = samp_of(first[2:0]);
				end
			end
			S_SAMP: begin
				if (cnt_r == 8'h00) begin
					st_nxt = S_CONV; // [R7]
					cnt_nxt = 8'(CONV_CYC - 1); // [R1]
				end else begin
					cnt_nxt = cnt_r - 8'h01;
				end
			end
			S_CONV: begin
				if (cnt_r != 8'h00) begin
					cnt_nxt = cnt_r - 8'h01;
				end else if (!sw_r && !later[3]) begin
					st_nxt = S_SAMP; // [R4]
					cur_nxt = later[2:0];
					cnt_nxt = samp_of(later[2:0]);
				end else if (!sw_r && cont_r && !first[3]) begin
					st_nxt = S_SAMP; // [R4]
					cur_nxt = first[2:0];
					cnt_nxt = samp_of(first[2:0]);
				end else begin
					st_nxt = S_IDLE;
				end
			end
			default: st_nxt = S_IDLE;
		endcase
		if (!running) begin
			st_nxt = S_IDLE; // [R12]
		end
	end

	// ****************************************
	// Events and interrupt
	// ****************************************
	wire [NEV-1:0] ev = {conv_done & ~sw_r & later[3], conv_done,
		conv_done & oor}; // [R9]
	// Set wins over a write-one-to-clear in the same cycle
	assign stat_nxt = (stat_r & ~w1c) | ev; // [R13]

	// Analog control word, registered so every pin comes from a flop
	always_comb begin
		ana_nxt.en = running;
		ana_nxt.sample = st_nxt == S_SAMP;
		ana_nxt.convert = st_nxt == S_CONV;
		ana_nxt.sel = cfg_r[cur_nxt].sel; // [R3] [R11]
		ana_nxt.refsel = ref_r; // [R10]
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			st_r <= S_IDLE;
			cur_r <= 3'h0;
			cnt_r <= 8'h00;
			stat_r <= '0;
			ana_r <= '0;
			irq_r <= 1'b0;
		end else if (clk_en) begin
			st_r <= st_nxt;
			cur_r <= cur_nxt;
			cnt_r <= cnt_nxt;
			stat_r <= stat_nxt;
			ana_r <= ana_nxt;
			irq_r <= |(stat_nxt & mask_r); // [R9]
		end
	end

	assign avs_waitrequest = wait_r;
	assign avs_readdata = rdata_r;
	assign ana = ana_r;
	assign irq = irq_r;

	// ****************************************
	// Assertions
	// ****************************************
	logic [7:0] conv_len;
	always_ff @(posedge sys_clk) begin
		if (reset || !ana_r.convert) begin
			conv_len <= 8'h00;
		end else if (conv_len != 8'hff) begin
			conv_len <= conv_len + 8'h01;
		end
	end
	wire tick_done = clk_en & conv_done;

	a_conv_min_len: assert property (@(posedge sys_clk) disable iff (reset) // [R1]
		$fell(ana_r.convert) && !$past(lp_mode) && $past(en_r) |->
		$past(conv_len) >= 8'(CONV_CYC - 1))
		else $error("conversion shorter than minimum");
	a_eoc_flag: assert property (@(posedge sys_clk) disable iff (reset) // [R2]
		tick_done |=> stat_r[ST_EOC])
		else $error("conversion end not flagged");
	a_sel_matches: assert property (@(posedge sys_clk) disable iff (reset) // [R3]
		ana_r.sample |-> ana_r.sel == cfg_r[cur_r].sel)
		else $error("input select differs from slot config");
	a_no_idle_gap: assert property (@(posedge sys_clk) disable iff (reset) // [R4]
		tick_done && running && !sw_r && !later[3] |=> st_r == S_SAMP ##0 ana_r.sample)
		else $error("idle gap between channels");
	a_sw_single: assert property (@(posedge sys_clk) disable iff (reset) // [R5]
		tick_done && sw_r |=> st_r == S_IDLE)
		else $error("software mode advanced on its own");
	a_result_kept: assert property (@(posedge sys_clk) disable iff (reset) // [R6]
		tick_done |=> res_r[$past(cur_r)].val == $past(sar_result))
		else $error("result not stored in channel buffer");
	a_sample_hold: assert property (@(posedge sys_clk) disable iff (reset) // [R7]
		clk_en && running && st_r == S_SAMP && cnt_r != 8'h00 |=> st_r == S_SAMP)
		else $error("sample window cut short");
	a_range_irq: assert property (@(posedge sys_clk) disable iff (reset) // [R9]
		tick_done && oor && mask_r[ST_RANGE] |=> irq && stat_r[ST_RANGE])
		else $error("out-of-range not raised");
	a_ref_follow: assert property (@(posedge sys_clk) disable iff (reset) // [R10]
		clk_en |=> ana_r.refsel == $past(ref_r))
		else $error("reference select not applied");
	a_lp_idle: assert property (@(posedge sys_clk) disable iff (reset) // [R12]
		clk_en && lp_mode |=> !ana_r.en && st_r == S_IDLE)
		else $error("converter active in low-power mode");
	a_flag_sticky: assert property (@(posedge sys_clk) disable iff (reset) // [R13]
		stat_r[ST_RANGE] && !w1c[ST_RANGE] |=> stat_r[ST_RANGE])
		else $error("range flag lost without clear");

	c_scan_done: cover property (@(posedge sys_clk) disable iff (reset)
		tick_done && ev[ST_SCAN]);
	c_range_hit: cover property (@(posedge sys_clk) disable iff (reset)
		tick_done && oor);
	c_sw_conv: cover property (@(posedge sys_clk) disable iff (reset)
		tick_done && sw_r);
endmodule

/* File: sarsc_top_tb_top.sv */
// Self-checking bench for the SAR sequencer control block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module sarsc_top_tb_top
	import sarsc_pkg::*;
;
	// ****************************************
	// Design, converter model and stimulus
	// ****************************************
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic clk_en = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [11:0] sar_result;
	logic lp_mode = 1'b0;
	sarsc_ana_s ana;
	logic irq;
	int mismatches = 0;
	int n_checks = 0;
	int cyc = 0;
	sarsc_top sarsc_top_inst (.sys_clk, .reset, .clk_en, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .sar_result, .lp_mode, .ana, .irq);
	sarsc_ana_model sarsc_ana_model_inst (.sys_clk, .ana, .sar_result);
	// 10 MHz clock
	always #50 sys_clk = ~sys_clk;

	// ****************************************
	// Converter-side monitor
	// ****************************************
	wire s_on = (ana.sample === 1'b1);
	wire c_on = (ana.convert === 1'b1);
	logic prev_s = 1'b0;
	logic prev_c = 1'b0;
	logic irq_seen = 1'b0;
	logic [3:0] last_sel = 4'h0;
	logic [3:0] q_sel[$];
	int q_samp[$];
	int q_gap[$];
	int samp_len = 0;
	int conv_len = 0;
	int idle_run = 0;
	int n_conv = 0;
	int irq_at = -1;
	// Window lengths, idle gaps and channel order, kept for later compares
	always @(posedge sys_clk) begin
		if (s_on && !prev_s) begin
			q_gap.push_back(idle_run);
			idle_run = 0;
		end
		if (!s_on && prev_s) begin
			q_samp.push_back(samp_len);
			samp_len = 0;
		end
		if (!c_on && prev_c) begin
			`CHK("convert length", CONV_CYC, conv_len)
			q_sel.push_back(last_sel);
			conv_len = 0;
			n_conv++;
		end
		// Frozen cycles do not count as converter clocks
		if (s_on && clk_en) samp_len++;
		if (c_on && clk_en) begin
			conv_len++;
			last_sel = ana.sel;
		end
		if (!s_on && !c_on && clk_en) idle_run++;
		if (irq === 1'b1 && !irq_seen) begin
			irq_seen = 1'b1;
			irq_at = n_conv;
		end
		prev_s = s_on;
		prev_c = c_on;
	end

	// ****************************************
	// Bus tasks and run control
	// ****************************************
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= 1'b1;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask
	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_read <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
		logic [31:0] d;
		bus_rd(a, d);
		`CHK(nm, e, d)
	endtask
	// Bounded poll: gives up quietly after 100 reads, so a flag that never comes cannot hang the run
	task automatic poll(input int b);
		logic [31:0] d;
		repeat (100) begin
			bus_rd(OFF_STAT, d);
			if (d[b] === 1'b1) break;
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// Cleared between edges so the monitor never races it
	task automatic clear_mon();
		@(negedge sys_clk);
		q_sel.delete();
		q_samp.delete();
		q_gap.delete();
		n_conv = 0;
		irq_seen = 1'b0;
		irq_at = -1;
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Hang guard, well above the few hundred cycles the tests need
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			complete_run();
		end
	end

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		logic [31:0] d;
		logic [11:0] v;
		int chs[4];
		sarsc_ana_s fz;
		chs = '{0, 2, 5, 7};
		tick(3);
		reset <= 1'b0;
		// Reset values, an unmapped place and byte lanes
		rd_chk(OFF_CHEN, {24'h0, CHEN_RST}, "chen reset");
		rd_chk(OFF_LIMIT, 32'h0fff0000, "limit reset");
		for (int i = 0; i < NCH; i++) rd_chk({BLK_CFG, 5'(4 * i)}, {16'h0, SAMP_RST, 4'h0, 4'(i)}, "cfg");
		bus_wr(8'h60, 32'hffffffff);
		rd_chk(8'h60, 32'h0, "unmapped");
		rd_chk(OFF_CMD, 32'h0, "cmd reads zero");
		bus_wr(OFF_LIMIT, 32'hffff0123, 4'h3);
		rd_chk(OFF_LIMIT, 32'h0fff0123, "limit lanes");
		// Auto scan of four slots, each with its own window
		for (int i = 0; i < NCH; i++) bus_wr({BLK_CFG, 5'(4 * i)}, {16'h0, 8'(i + 1), 4'h0, 4'(i)});
		bus_wr(OFF_CHEN, 32'ha5);
		bus_wr(OFF_LIMIT, 32'h0c000100);
		bus_wr(OFF_MASK, 32'h1);
		bus_wr(OFF_CTRL, 32'h1);
		clear_mon();
		bus_wr(OFF_CMD, 32'h1);
		poll(ST_SCAN);
		rd_chk(OFF_STAT, 32'h7, "scan status");
		`CHK("scan conversions", 4, n_conv)
		`CHK("irq before scan end", 1, irq_at)
		for (int k = 0; k < 4; k++) begin
			`CHK("scan order", chs[k], q_sel[k])
			`CHK("sample window", chs[k] + 1, q_samp[k])
			if (k > 0) `CHK("idle between", 0, q_gap[k])
			v = 12'(chs[k]) * 12'h1f0 + 12'h010;
			rd_chk({BLK_RES, 5'(4 * chs[k])}, {15'h0, (v < 12'h100 || v > 12'hc00), 4'h0, v}, "result");
		end
		rd_chk({BLK_RES, 5'h04}, 32'h0, "disabled slot");
		// Clear only the range flag, then the rest
		bus_wr(OFF_STAT, 32'h1);
		tick(2);
		`CHK("irq after clear", 1'b0, irq)
		rd_chk(OFF_STAT, 32'h6, "w1c");
		bus_wr(OFF_STAT, 32'h6);
		bus_wr(OFF_MASK, 32'h0);
		// Software-switched conversion of the temperature sensor, masked
		bus_wr({BLK_CFG, 5'h0c}, {16'h0, 8'h04, 4'h0, SEL_TEMP});
		bus_wr(OFF_CTRL, 32'h3);
		clear_mon();
		bus_wr(OFF_CMD, 32'h31);
		poll(ST_EOC);
		rd_chk(OFF_STAT, 32'h3, "sw status");
		`CHK("temp select", SEL_TEMP, q_sel[0])
		`CHK("sw sample window", 4, q_samp[0])
		`CHK("sw conversions", 1, n_conv)
		`CHK("masked irq", 1'b0, irq)
		rd_chk({BLK_RES, 5'h0c}, 32'h10f90, "temp result");
		bus_wr(OFF_MASK, 32'h1);
		tick(2);
		`CHK("unmasked irq", 1'b1, irq)
		// Every reference code
		for (int r = 0; r < 4; r++) begin
			bus_wr(OFF_CTRL, 32'(r << CTRL_REF) | 32'h1);
			tick(2);
			`CHK("refsel", 2'(r), ana.refsel)
		end
		// Deep low-power mode holds everything idle
		lp_mode <= 1'b1;
		tick(2);
		`CHK("enable in low power", 1'b0, ana.en)
		clear_mon();
		bus_wr(OFF_CMD, 32'h1);
		tick(40);
		`CHK("low power conversions", 0, n_conv)
		bus_rd(OFF_STATE, d);
		`CHK("state low power", 3'b100, {d[STA_LP], d[1:0]})
		lp_mode <= 1'b0;
		// Continuous scan of slots 0 and 7 restarts with no go and no gap at the wrap
		bus_wr(OFF_STAT, 32'h7);
		bus_wr(OFF_CHEN, 32'h81);
		clear_mon();
		bus_wr(OFF_CTRL, 32'h11);
		poll(ST_SCAN);
		bus_wr(OFF_STAT, 32'h4);
		poll(ST_SCAN);
		rd_chk(OFF_STAT, 32'h7, "cont status");
		`CHK("wrap order", 0, q_sel[2])
		`CHK("wrap gap", 0, q_gap[2])
		// Clock enable low freezes the converter controls mid-scan
		clk_en <= 1'b0;
		tick(1);
		fz = ana;
		tick(5);
		`CHK("frozen by clock enable", fz, ana)
		clk_en <= 1'b1;
		// Dropping continuous lets the pass finish, then the sequencer rests
		bus_wr(OFF_CTRL, 32'h1);
		tick(100);
		clear_mon();
		tick(60);
		`CHK("stopped after continuous off", 0, n_conv)
		rd_chk(OFF_STATE, 32'h70, "state after stop");
		complete_run();
	end
endmodule
